/* inc/dcc_pkg.sv */
// dcc_pkg: constants, types and register map of the coalescing control block.
// assumes a 10 MHz core clock and a 32-bit classic wishbone register bus.
package dcc_pkg;

  // clock and watchdog time base
  localparam int unsigned DCC_CLK_PERIOD_NS = 100;
  localparam int unsigned DCC_WDOG_UNIT_NS = 32768;
  localparam int unsigned DCC_WDOG_TICK_CYC = DCC_WDOG_UNIT_NS / DCC_CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [15:0] DCC_XOFF_WM_OFF = 16'h2170;
  localparam logic [15:0] DCC_CTRL_OFF = 16'h2508;
  localparam logic [15:0] DCC_LX_OFF = 16'h2514;
  localparam logic [15:0] DCC_STATUS_OFF = 16'h2518;
  localparam logic [15:0] DCC_TX_TH_OFF = 16'h3550;
  localparam logic [15:0] DCC_RX_CNT_OFF = 16'h5dd4;
  localparam logic [15:0] DCC_MGMT_TH_OFF = 16'h8f30;

  // field positions
  localparam int unsigned DCC_WDOG_LSB = 0;
  localparam int unsigned DCC_M2H_BIT = 15;
  localparam int unsigned DCC_RXTH_LSB = 16;
  localparam int unsigned DCC_FORCE_BIT = 25;
  localparam int unsigned DCC_EN_BIT = 31;
  localparam int unsigned DCC_TXTH_LSB = 0;
  localparam int unsigned DCC_MGTH_LSB = 4;
  localparam int unsigned DCC_FLUSH_DIS_BIT = 31;
  localparam int unsigned DCC_WM_LSB = 4;

  // reset values
  localparam logic [13:0] DCC_WDOG_RST = 14'h0020;
  localparam logic DCC_M2H_RST = 1'b1;
  localparam logic [7:0] DCC_RXTH_RST = 8'h00;
  localparam logic [11:0] DCC_TXTH_RST = 12'h0e4;
  localparam logic [15:0] DCC_MGTH_RST = 16'h0100;
  localparam logic [13:0] DCC_WM_RST = 14'h0000;
  localparam logic [1:0] DCC_CTRL_RSV_RD = 2'h3;
  localparam logic [11:0] DCC_LX_RSV_RD = 12'h020;
  localparam logic [24:0] DCC_CNT_MAX = 25'h1ff_ffff;

  // buffer level width in bits; the levels count bytes
  localparam int unsigned DCC_LVL_W = 20;

  typedef enum logic [1:0] {
    DCC_IDLE = 2'h0,
    DCC_FLUSH = 2'h1,
    DCC_COAL = 2'h3,
    DCC_EXIT = 2'h2
  } dcc_state_e;

  // software-written configuration
  typedef struct packed {
    logic en;
    logic force_exit;
    logic [7:0] rx_thr;
    logic m2h_en;
    logic [13:0] wdog_limit;
    logic [11:0] tx_thr;
    logic [15:0] mgmt_thr;
    logic flush_dis;
    logic [13:0] xoff_wm;
  } dcc_cfg_s;

  // traffic events, one-cycle pulses
  typedef struct packed {
    logic rx_pkt;
    logic tx_req;
    logic int_cause;
    logic mgmt_to_host;
    logic rx_seg;
    logic interval_end;
  } dcc_evt_s;

  // buffer and datapath levels
  typedef struct packed {
    logic [DCC_LVL_W-1:0] rx_used;
    logic [DCC_LVL_W-1:0] tx_free;
    logic [11:0] max_tx_pkt;
    logic tx_pending;
    logic tx_fifo_empty;
    logic tx_flow_ctrl_en;
  } dcc_lvl_s;

endpackage : dcc_pkg

/* rtl/dcc_top.sv */
// dcc_top: dma coalescing control with its wishbone register file.
// assumes all inputs synchronous to clk_i; one wishbone master.
//
// How it works
// - watchdog in 32.768 us units bounds coalescing
// - zero watchdog limit disables watchdog exit
// - management traffic starts watchdog when enabled
// - zero limit plus enable: management traffic exits
// - rx fill above threshold ends coalescing
// - zero rx threshold disables that exit
// - force-exit bit exits once, clears itself
// - enable bit turns coalescing on, resets off
// - tx free space plus pending data exits
// - zero or too small tx threshold disables
// - management free-space threshold exits, zero disables
// - management compare may deviate sixteen bytes
// - flush interrupts and write-backs before entry
// - saturating 25-bit rx segment counter
// - xoff at watermark while coalescing, flow control
`timescale 1ns/1ps

module dcc_top
  import dcc_pkg::*;
#(
  parameter int unsigned TICK_CYC = DCC_WDOG_TICK_CYC
) (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [15:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire dcc_evt_s evt_i, // traffic event pulses
  input wire dcc_lvl_s lvl_i, // buffer levels
  input wire logic dma_idle_i, // host dma quiet
  input wire logic flush_done_i, // flush finished
  output logic flush_req_o, // flush interrupts, write-backs
  output logic dma_defer_o, // hold off host dma
  output logic link_l0_req_o, // one-cycle wake request
  output logic xoff_send_o, // one-cycle xoff request
  output logic coal_active_o // coalescing state
);

  ////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge of a write into the current word
  function automatic logic [31:0] wb_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        res[i*8 +: 8] = new_w[i*8 +: 8];
    end
    return res;
  endfunction : wb_merge

  // address match on the word-aligned part
  function automatic logic hit(input logic [15:0] adr, input logic [15:0] off);
    return adr[15:2] == off[15:2];
  endfunction : hit

  ////////////////////////////////////////////////////////////////
  // declarations

  dcc_cfg_s cfg_q, cfg_d;
  dcc_state_e st_q, st_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [31:0] rd_word;
  logic [15:0] tick_q, tick_d;
  logic tick;
  logic wd_run_q, wd_run_d;
  logic [13:0] wd_cnt_q, wd_cnt_d;
  logic [24:0] cnt_q, cnt_d;
  logic [5:0] why_q, why_d;
  logic xoff_cond, xoff_q, xoff_d;
  logic l0_q, l0_d;
  logic wd_event, wd_expire, mgmt_now, rx_hit, tx_hit, mg_hit;
  logic [5:0] why_now;
  logic wr_acc;

  ////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after the strobe, write at the ack edge

  assign wr_acc = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;

  // read mux; unmapped addresses read zero and are still acked
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (hit(wb_adr_i, DCC_CTRL_OFF))
      rd_word = {cfg_q.en, 1'b0, DCC_CTRL_RSV_RD, 2'b00, cfg_q.force_exit, 1'b0,
                 cfg_q.rx_thr, cfg_q.m2h_en, 1'b0, cfg_q.wdog_limit};
    else if (hit(wb_adr_i, DCC_LX_OFF))
      rd_word = {cfg_q.flush_dis, 19'h0_0000, DCC_LX_RSV_RD};
    else if (hit(wb_adr_i, DCC_TX_TH_OFF))
      rd_word = {20'h0_0000, cfg_q.tx_thr};
    else if (hit(wb_adr_i, DCC_MGMT_TH_OFF))
      rd_word = {12'h000, cfg_q.mgmt_thr, 4'h0};
    else if (hit(wb_adr_i, DCC_RX_CNT_OFF))
      rd_word = {7'h00, cnt_q};
    else if (hit(wb_adr_i, DCC_XOFF_WM_OFF))
      rd_word = {14'h0000, cfg_q.xoff_wm, 4'h0};
    else if (hit(wb_adr_i, DCC_STATUS_OFF))
      rd_word = {24'h00_0000, why_q, st_q};
  end

  // ack and read data capture
  always_comb
  begin
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    dat_d = dat_q;
    if (ack_d)
      dat_d = rd_word;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  ////////////////////////////////////////////////////////////////
  // configuration registers

  // force-exit lives one cycle so a write yields a single exit
  always_comb
  begin
    logic [31:0] w;
    w = wb_merge(rd_word, wb_dat_i, wb_sel_i);
    cfg_d = cfg_q;
    cfg_d.force_exit = 1'b0;
    if (wr_acc && hit(wb_adr_i, DCC_CTRL_OFF))
    begin
      cfg_d.wdog_limit = w[DCC_WDOG_LSB +: 14];
      cfg_d.m2h_en = w[DCC_M2H_BIT];
      cfg_d.rx_thr = w[DCC_RXTH_LSB +: 8];
      cfg_d.force_exit = w[DCC_FORCE_BIT] & wb_sel_i[3];
      cfg_d.en = w[DCC_EN_BIT];
    end
    if (wr_acc && hit(wb_adr_i, DCC_LX_OFF))
      cfg_d.flush_dis = w[DCC_FLUSH_DIS_BIT];
    if (wr_acc && hit(wb_adr_i, DCC_TX_TH_OFF))
      cfg_d.tx_thr = w[DCC_TXTH_LSB +: 12];
    if (wr_acc && hit(wb_adr_i, DCC_MGMT_TH_OFF))
      cfg_d.mgmt_thr = w[DCC_MGTH_LSB +: 16];
    if (wr_acc && hit(wb_adr_i, DCC_XOFF_WM_OFF))
      cfg_d.xoff_wm = w[DCC_WM_LSB +: 14];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_q.en <= 1'b0;
      cfg_q.force_exit <= 1'b0;
      cfg_q.rx_thr <= DCC_RXTH_RST;
      cfg_q.m2h_en <= DCC_M2H_RST;
      cfg_q.wdog_limit <= DCC_WDOG_RST;
      cfg_q.tx_thr <= DCC_TXTH_RST;
      cfg_q.mgmt_thr <= DCC_MGTH_RST;
      cfg_q.flush_dis <= 1'b0;
      cfg_q.xoff_wm <= DCC_WM_RST;
    end
    else
      cfg_q <= cfg_d;
  end

  ////////////////////////////////////////////////////////////////
  // exit conditions

  // thresholds scaled to bytes; the mgmt compare is exact, inside the
  // sixteen-byte tolerance the device is allowed
  always_comb
  begin
    rx_hit = (cfg_q.rx_thr != 8'h00) &&
             (lvl_i.rx_used > {2'b00, cfg_q.rx_thr, 10'h000});
    tx_hit = (cfg_q.tx_thr != 12'h000) && (cfg_q.tx_thr >= lvl_i.max_tx_pkt) &&
             lvl_i.tx_pending &&
             (lvl_i.tx_free > {2'b00, cfg_q.tx_thr, 6'h00});
    mg_hit = (cfg_q.mgmt_thr != 16'h0000) &&
             (lvl_i.tx_free > {cfg_q.mgmt_thr, 4'h0});
    mgmt_now = (cfg_q.wdog_limit == 14'h0000) && cfg_q.m2h_en &&
               evt_i.mgmt_to_host;
    why_now = {cfg_q.force_exit, mg_hit, tx_hit, rx_hit, mgmt_now, wd_expire};
  end

  ////////////////////////////////////////////////////////////////
  // watchdog: time base and limit counter

  // management traffic only counts when its enable bit is set
  always_comb
  begin
    wd_event = evt_i.rx_pkt | evt_i.tx_req | evt_i.int_cause |
               (cfg_q.m2h_en & evt_i.mgmt_to_host);
    wd_expire = wd_run_q && (cfg_q.wdog_limit != 14'h0000) &&
                (wd_cnt_q >= cfg_q.wdog_limit);
    tick = (tick_q == 16'(TICK_CYC - 1));
    tick_d = tick ? 16'h0000 : tick_q + 16'h0001;
    wd_run_d = wd_run_q;
    wd_cnt_d = wd_cnt_q;
    if (st_q != DCC_COAL)
    begin
      wd_run_d = 1'b0;
      wd_cnt_d = 14'h0000;
    end
    else if (wd_event && !wd_run_q)
    begin
      wd_run_d = 1'b1;
      wd_cnt_d = 14'h0000;
      tick_d = 16'h0000; // restart time base for an even first unit
    end
    else if (wd_run_q && tick && wd_cnt_q != 14'h3fff)
      wd_cnt_d = wd_cnt_q + 14'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tick_q <= 16'h0000;
      wd_run_q <= 1'b0;
      wd_cnt_q <= 14'h0000;
    end
    else
    begin
      tick_q <= tick_d;
      wd_run_q <= wd_run_d;
      wd_cnt_q <= wd_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // coalescing state machine

  // entry waits for idle dma and no pending wake reason, else it would bounce
  always_comb
  begin
    st_d = st_q;
    l0_d = 1'b0;
    why_d = why_q;
    unique case (st_q)
      DCC_IDLE:
        if (cfg_q.en && dma_idle_i && !cfg_q.force_exit &&
            !(rx_hit | tx_hit | mg_hit))
          st_d = DCC_FLUSH;
      DCC_FLUSH:
        if (!cfg_q.en || cfg_q.force_exit)
          st_d = DCC_IDLE;
        else if (cfg_q.flush_dis || flush_done_i)
          st_d = DCC_COAL;
      DCC_COAL:
        if (!cfg_q.en || (why_now != 6'h00))
        begin
          st_d = DCC_EXIT;
          l0_d = 1'b1;
          why_d = why_now;
        end
      DCC_EXIT:
        st_d = DCC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= DCC_IDLE;
      l0_q <= 1'b0;
      why_q <= 6'h00;
    end
    else
    begin
      st_q <= st_d;
      l0_q <= l0_d;
      why_q <= why_d;
    end
  end

  // host dma held off only in the coalescing state
  assign dma_defer_o = (st_q == DCC_COAL);
  assign coal_active_o = (st_q == DCC_COAL);
  assign flush_req_o = (st_q == DCC_FLUSH) && !cfg_q.flush_dis;
  assign link_l0_req_o = l0_q;

  ////////////////////////////////////////////////////////////////
  // receive segment counter and xoff

  // new interval restarts the count; a segment in that cycle still counts
  always_comb
  begin
    cnt_d = cnt_q;
    if (evt_i.interval_end)
      cnt_d = evt_i.rx_seg ? 25'h000_0001 : 25'h000_0000;
    else if (evt_i.rx_seg && cnt_q != DCC_CNT_MAX)
      cnt_d = cnt_q + 25'h000_0001;
    xoff_cond = (st_q == DCC_COAL) && lvl_i.tx_fifo_empty && lvl_i.tx_flow_ctrl_en &&
                (lvl_i.rx_used >= {2'b00, cfg_q.xoff_wm, 4'h0});
    xoff_d = xoff_cond;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 25'h000_0000;
      xoff_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      xoff_q <= xoff_d;
    end
  end

  // one xoff per rise of the condition, not one per cycle
  assign xoff_send_o = xoff_cond & ~xoff_q;

  ////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wdog_exit_a: assert property ((st_q == DCC_COAL) && wd_expire |=> st_q == DCC_EXIT)
    else $error("watchdog expiry did not leave coalescing");
  wdog_zero_a: assert property ((cfg_q.wdog_limit == 14'h0000) |-> !wd_expire)
    else $error("watchdog expired with zero limit");
  mgmt_start_a: assert property ((st_q == DCC_COAL) && (st_d == DCC_COAL) && cfg_q.m2h_en &&
                                 evt_i.mgmt_to_host |=> wd_run_q)
    else $error("management traffic did not start watchdog");
  mgmt_exit_a: assert property ((st_q == DCC_COAL) && cfg_q.m2h_en && evt_i.mgmt_to_host &&
                                (cfg_q.wdog_limit == 14'h0000) |=> link_l0_req_o)
    else $error("management traffic did not exit");
  rx_exit_a: assert property ((st_q == DCC_COAL) && rx_hit |=> why_q[2] && link_l0_req_o)
    else $error("rx fill did not exit");
  force_once_a: assert property (cfg_q.force_exit |=> !cfg_q.force_exit)
    else $error("force exit bit did not clear");
  enable_off_a: assert property (!cfg_q.en [*2] |-> st_q != DCC_COAL ##1 st_q != DCC_COAL)
    else $error("coalescing while disabled");
  tx_exit_a: assert property ((st_q == DCC_COAL) && tx_hit |=> why_q[3] && st_q == DCC_EXIT)
    else $error("tx free space did not exit");
  flush_a: assert property ($rose(st_q == DCC_COAL) |-> $past(cfg_q.flush_dis) ||
                            $past(flush_done_i))
    else $error("entered coalescing without flush");
  cnt_sat_a: assert property ((cnt_q == DCC_CNT_MAX) && !evt_i.interval_end |=>
                              cnt_q == DCC_CNT_MAX)
    else $error("rx count wrapped");
  xoff_a: assert property ($rose(xoff_cond) |-> xoff_send_o ##1 !xoff_send_o)
    else $error("xoff not sent once");
  defer_a: assert property ((st_q == DCC_COAL) |-> dma_defer_o && !flush_req_o)
    else $error("dma not deferred while coalescing");

  enter_c: cover property (st_q == DCC_FLUSH ##[1:20] st_q == DCC_COAL);
  wdog_c: cover property (st_q == DCC_COAL && wd_expire);
  xoff_c: cover property (xoff_send_o);
  force_c: cover property (st_q == DCC_COAL && cfg_q.force_exit);

endmodule : dcc_top

/* testbench/dcc_host_model.sv */
// dcc_host_model: host side facing the coalescing block.
// assumes flush requests are levels held until answered.
`timescale 1ns/1ps

module dcc_host_model (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic flush_req_i, // flush request level
  input wire logic busy_i, // bench keeps dma busy
  input wire logic [3:0] delay_i, // flush answer delay
  output logic flush_done_o, // flush finished
  output logic dma_idle_o, // host dma quiet
  output int flush_cnt_o // flushes seen
);
  logic [3:0] wait_q;
  logic req_q;

  ////////////////////////////////////////
  // answer each flush delay_i+1 cycles after the request is seen, prompt or slow
  always @(posedge clk_i)
  begin
    req_q <= flush_req_i;
    if (rst_i || !flush_req_i)
    begin
      wait_q <= 4'h0;
      flush_done_o <= 1'b0;
    end
    else
    begin
      wait_q <= wait_q + 4'h1;
      flush_done_o <= (wait_q == delay_i);
    end
    if (rst_i)
      flush_cnt_o <= 0;
    else if (flush_req_i && !req_q)
      flush_cnt_o <= flush_cnt_o + 1;
  end

  // dma counts as quiet outside reset unless the bench holds it busy
  assign dma_idle_o = !rst_i && !busy_i;
endmodule : dcc_host_model

/* testbench/dcc_top_test.sv */
// dcc_top_test: register-level sequences for the coalescing block.
// assumes the host model answers flushes; every wait is bounded.
`timescale 1ns/1ps

module dcc_top_test;
  import dcc_pkg::*;
  localparam int unsigned TICK = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [15:0] wb_adr = 16'h0000;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd_q;
  logic wb_ack_o, flush_req, flush_done, dma_idle, defer, l0_req, xoff, active;
  logic busy = 1'b0;
  logic [3:0] fl_delay = 4'h3;
  dcc_evt_s evt = '0;
  dcc_lvl_s lvl = '0;
  int flush_cnt;
  int err_total = 0;
  int n_checks = 0;
  int l0_cnt = 0;
  int xoff_cnt = 0;
  int base = 0;
  int c;

  dcc_top #(.TICK_CYC(TICK)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .evt_i(evt), .lvl_i(lvl), .dma_idle_i(dma_idle),
    .flush_done_i(flush_done), .flush_req_o(flush_req), .dma_defer_o(defer),
    .link_l0_req_o(l0_req), .xoff_send_o(xoff), .coal_active_o(active));

  dcc_host_model host (
    .clk_i(clk_i), .rst_i(rst_i), .flush_req_i(flush_req), .busy_i(busy),
    .delay_i(fl_delay), .flush_done_o(flush_done), .dma_idle_o(dma_idle),
    .flush_cnt_o(flush_cnt));

  ////////////////////////////////////////
  // 10 MHz clock
  initial
    forever #50 clk_i = ~clk_i;

  // count one-cycle pulses; a stuck pulse shows as an overcount
  always @(posedge clk_i)
  begin
    if (l0_req === 1'b1)
      l0_cnt <= l0_cnt + 1;
    if (xoff === 1'b1)
      xoff_cnt <= xoff_cnt + 1;
  end

  ////////////////////////////////////////
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  task chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32

  task chk1(input string nm, input logic e, input logic g);
    chk32(nm, {31'h0, e}, {31'h0, g});
  endtask : chk1

  // classic cycle; ack and read data taken at the rising edge, released right after it
  task wb(input logic we, input logic [15:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 4'hf;
    wb_adr <= a;
    wb_dat <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && t < 20)
    begin
      t++;
      @(posedge clk_i);
    end
    chk1("wb_ack", 1'b1, wb_ack_o);
    rd_q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  task rd(input string nm, input logic [15:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk32(nm, e, rd_q);
  endtask : rd

  function automatic logic [31:0] ctl(input logic en, input logic fx, input logic [7:0] rx,
                                      input logic m2h, input logic [13:0] lim);
    return {en, 3'b011, 2'b00, fx, 1'b0, rx, m2h, 1'b0, lim};
  endfunction : ctl

  task pulse(input dcc_evt_s e);
    @(posedge clk_i);
    evt <= e;
    @(posedge clk_i);
    evt <= '0;
  endtask : pulse

  // enable, wait for entry, check the flush count it cost
  task coal_on(input logic [31:0] v, input int fl);
    int f;
    int t;
    f = flush_cnt;
    t = 0;
    wb(1'b1, DCC_CTRL_OFF, v);
    while (active !== 1'b1 && t < 40)
    begin
      t++;
      @(negedge clk_i);
    end
    chk1("dma_defer", 1'b1, defer);
    chk32("flushes", 32'(f + fl), 32'(flush_cnt));
    base = l0_cnt;
  endtask : coal_on

  // ends on a rising edge so that the next stimulus lands there
  task no_exit(input int n);
    repeat (n) @(posedge clk_i);
    chk32("l0_pulses", 32'(base), 32'(l0_cnt));
    chk1("dma_defer", 1'b1, defer);
  endtask : no_exit

  // wait for the wake pulse, check its cause, then disable
  task exit_by(input int n, input logic [5:0] why);
    int t;
    t = 0;
    while (l0_cnt == base && t < n)
    begin
      t++;
      @(negedge clk_i);
    end
    chk32("l0_pulses", 32'(base + 1), 32'(l0_cnt));
    chk1("dma_defer", 1'b0, defer);
    wb(1'b0, DCC_STATUS_OFF, 32'h0000_0000);
    chk32("exit_reason", {26'h0, why}, {26'h0, rd_q[7:2]});
    wb(1'b1, DCC_CTRL_OFF, 32'h3000_0000);
  endtask : exit_by

  ////////////////////////////////////////
  // hang guard, far beyond the expected run
  initial
  begin
    repeat (8000) @(posedge clk_i);
    err_total++;
    $display("wrong value watchdog expected done seen timeout");
    summarize();
  end

  // main sequence
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("ctrl", DCC_CTRL_OFF, 32'h3000_8020);
    rd("lx", DCC_LX_OFF, 32'h0000_0020);
    rd("tx_thr", DCC_TX_TH_OFF, 32'h0000_00e4);
    rd("mgmt_thr", DCC_MGMT_TH_OFF, 32'h0000_1000);
    rd("xoff_wm", DCC_XOFF_WM_OFF, 32'h0000_0000);
    rd("rx_count", DCC_RX_CNT_OFF, 32'h0000_0000);
    rd("unmapped", 16'h0100, 32'h0000_0000);
    $display("test reset_values done");
    // busy dma blocks entry; management traffic with zero limit exits
    @(posedge clk_i);
    busy <= 1'b1;
    wb(1'b1, DCC_CTRL_OFF, ctl(1'b1, 1'b0, 8'h00, 1'b1, 14'h0000));
    repeat (20) @(negedge clk_i);
    chk1("coal_active", 1'b0, active);
    @(posedge clk_i);
    busy <= 1'b0;
    coal_on(ctl(1'b1, 1'b0, 8'h00, 1'b1, 14'h0000), 1);
    pulse(6'h04);
    exit_by(6, 6'h02);
    $display("test entry_gate done");
    // no flush, zero limit and zero rx threshold; then forced exit
    wb(1'b1, DCC_LX_OFF, 32'h8000_0020);
    coal_on(ctl(1'b1, 1'b0, 8'h00, 1'b0, 14'h0000), 0);
    @(posedge clk_i);
    lvl.rx_used <= 20'hf_ffff;
    pulse(6'h38);
    no_exit(40);
    wb(1'b1, DCC_CTRL_OFF, ctl(1'b1, 1'b1, 8'h00, 1'b0, 14'h0000));
    rd("ctrl", DCC_CTRL_OFF, ctl(1'b1, 1'b0, 8'h00, 1'b0, 14'h0000));
    exit_by(4, 6'h20);
    lvl.rx_used <= 20'h0_0000;
    wb(1'b1, DCC_LX_OFF, 32'h0000_0020);
    $display("test force_exit done");
    // rx threshold 2 KB (xoff held off, tx fifo not empty), exact boundary
    coal_on(ctl(1'b1, 1'b0, 8'h02, 1'b0, 14'h0000), 1);
    @(posedge clk_i);
    lvl.rx_used <= 20'h0_0800;
    no_exit(10);
    lvl.rx_used <= 20'h0_0801;
    exit_by(6, 6'h04);
    lvl.rx_used <= 20'h0_0000;
    $display("test rx_threshold done");
    // tx threshold below max packet is off; zero mgmt threshold is off
    wb(1'b1, DCC_MGMT_TH_OFF, 32'h0000_0000);
    lvl.max_tx_pkt <= 12'h0e5;
    lvl.tx_pending <= 1'b1;
    lvl.tx_free <= 20'h0_3901;
    coal_on(ctl(1'b1, 1'b0, 8'h00, 1'b0, 14'h0000), 1);
    no_exit(10);
    lvl.max_tx_pkt <= 12'h010;
    exit_by(6, 6'h08);
    lvl.tx_pending <= 1'b0;
    lvl.tx_free <= 20'h0_0000;
    $display("test tx_threshold done");
    // mgmt threshold 256 bytes, exact boundary
    wb(1'b1, DCC_MGMT_TH_OFF, 32'h0000_0100);
    coal_on(ctl(1'b1, 1'b0, 8'h00, 1'b0, 14'h0000), 1);
    @(posedge clk_i);
    lvl.tx_free <= 20'h0_0100;
    no_exit(10);
    lvl.tx_free <= 20'h0_0101;
    exit_by(6, 6'h10);
    lvl.tx_free <= 20'h0_0000;
    $display("test mgmt_threshold done");
    // each traffic kind starts a 5-tick watchdog; flush answer speed varies
    for (int i = 0; i < 4; i++)
    begin
      fl_delay <= 4'(i);
      coal_on(ctl(1'b1, 1'b0, 8'h00, 1'b1, 14'h0005), 1);
      pulse(6'h04 << i);
      no_exit(16);
      exit_by(10, 6'h01);
    end
    $display("test watchdog done");
    // segment count and interval restart
    repeat (5) pulse(6'h02);
    rd("rx_count", DCC_RX_CNT_OFF, 32'h0000_0005);
    pulse(6'h01);
    rd("rx_count", DCC_RX_CNT_OFF, 32'h0000_0000);
    $display("test rx_count done");
    // xoff at a 64-byte watermark, only while coalescing
    wb(1'b1, DCC_XOFF_WM_OFF, 32'h0000_0040);
    lvl.tx_fifo_empty <= 1'b1;
    lvl.tx_flow_ctrl_en <= 1'b1;
    lvl.rx_used <= 20'h0_0040;
    c = xoff_cnt;
    repeat (5) @(negedge clk_i);
    chk32("xoff_pulses", 32'(c), 32'(xoff_cnt));
    coal_on(ctl(1'b1, 1'b0, 8'h00, 1'b0, 14'h0000), 1);
    @(posedge clk_i);
    lvl.rx_used <= 20'h0_003f;
    repeat (3) @(posedge clk_i);
    lvl.rx_used <= 20'h0_0040;
    repeat (3) @(negedge clk_i);
    chk32("xoff_pulses", 32'(c + 2), 32'(xoff_cnt));
    wb(1'b1, DCC_CTRL_OFF, 32'h3000_0000);
    repeat (4) @(negedge clk_i);
    chk1("dma_defer", 1'b0, defer);
    chk32("l0_pulses", 32'(base + 1), 32'(l0_cnt));
    $display("test xoff_and_disable done");
    summarize();
  end
endmodule : dcc_top_test
